// ---- pkg/usb_regs_map.svh ----
// Register offsets, field positions and reset values for the USB device register bank.
`ifndef USB_REGS_MAP_SVH
`define USB_REGS_MAP_SVH
`define OFS_EVENT_FLAGS 8'h00
`define OFS_INTERRUPT_MASK 8'h04
`define OFS_BUFFER_READY 8'h08
`define OFS_TEST_MODE 8'h0c
`define BIT_MASTER_EN 0
`define BIT_USB_RESET 8
`define BIT_SUSPEND 9
`define IRQ_SOURCE_MASK 32'hffff_fffe
`define BIT_DISCONNECT 10
`define BIT_EP0_RX 11
`define BIT_EP0_TX 12
`define BIT_SETUP 13
`define BIT_SOF 14
`define BIT_HIGH_SPEED 15
`define BIT_BUF2_LO 16
`define BIT_UNUSED 23
`define BIT_BUF1_LO 24
`define BIT_EP0_BUF 31
`define INT_MASK_WMASK 32'hff7f_ff01
`define BUF_READY_WMASK 32'hff7f_0000
`define TEST_MODE_LSB 29
`define RESET_WORD 32'h0000_0000
`endif

// ---- pkg/usb_regs_pkg.sv ----
// Types shared by the USB device register bank.
package usb_regs_pkg;
    typedef enum logic [2:0] {
        TM_NORMAL = 3'h0,
        TM_TEST_J = 3'h1,
        TM_TEST_K = 3'h2,
        TM_TEST_NAK = 3'h3,
        TM_TEST_PACKET = 3'h4
    } test_mode_e;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h1,
        BUS_ACK = 2'h2
    } bus_state_e;
endpackage

// ---- rtl/sync_bits.sv ----
// Two-stage synchroniser for a vector of pin-level inputs.
`timescale 1ns/1ps
module sync_bits #(
    parameter int WIDTH = 8
) (
    input wire logic clk, // Clock.
    input wire logic arst_n, // Async reset, active low.
    input wire logic [WIDTH-1:0] async_in, // Unsynchronised levels.
    output logic [WIDTH-1:0] sync_out // Synchronised levels.
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    always_comb begin
        next_stage1 = async_in;
        next_sync_out = stage1;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule

// ---- rtl/usb_device_irq_bufready_testmode_regs.sv ----
// Interrupt mask, event flags, buffer-ready handshake and test-mode registers of the USB device core.
`timescale 1ns/1ps
`include "usb_regs_map.svh"
// Overview of operation
// - Mask bit 10 lets cable disconnect raise the interrupt.
// - Mask bit 11 lets an endpoint zero data reception raise the interrupt.
// - Mask bit 12 lets an endpoint zero transmit completion raise the interrupt.
// - Mask bit 13 lets a received setup packet raise the interrupt.
// - Mask bit 14 lets each start-of-frame raise the interrupt.
// - Mask bit 15 raises the interrupt while running at high speed.
// - Mask bits 16-22 gate second-buffer completions of endpoints 7..1; bit 23 unused.
// - Mask bits 24-30 gate first-buffer completions 7..1; bit 31 endpoint zero buffer.
// - A buffer whose ready bit is zero answers IN or OUT with NAK.
// - Endpoint direction bit decides whether a ready buffer transmits or receives.
// - Ready register: bits 16-22 second buffers, 24-31 first buffers, rest read zero.
// - Endpoint zero has a single buffer serving both directions.
// - Test-mode field bits 29-31: normal, J, K, NAK, packet.
// - Reading the setup packet from buffer memory clears the setup flag.
// - Mask bit 0 is a master gate over every interrupt source.
// - Event flags clear on read; the interrupt drops once its flag clears.
// - After the host accepts IN data the ready bit of that buffer clears.
// - OUT to a busy buffer gets NAK; a free buffer stores and acknowledges.
module usb_device_irq_bufready_testmode_regs #(
    parameter int EP_COUNT = 8
) (
    input wire logic clk, // Bus clock, 100 MHz.
    input wire logic arst_n, // Async reset, active low.
    input wire logic bus_select, // Slave select, held for the whole access.
    input wire logic bus_rnw, // One for read, zero for write.
    input wire logic [7:0] bus_addr, // Byte address of the register.
    input wire logic [31:0] bus_wdata, // Write data.
    output logic [31:0] bus_rdata, // Read data, zero outside an answer.
    output logic bus_ack, // One-cycle transfer acknowledge.
    input wire logic line_disconnect, // Cable unplugged level from the PHY side.
    input wire logic line_high_speed, // High speed operation level.
    input wire logic line_reset, // Bus reset level.
    input wire logic line_suspend, // Suspend level.
    input wire logic ep0_rx_done, // Pulse: endpoint zero data packet received.
    input wire logic ep0_tx_done, // Pulse: endpoint zero data packet sent.
    input wire logic setup_rx, // Pulse: setup packet received.
    input wire logic sof_rx, // Pulse: start-of-frame received.
    input wire logic setup_read, // Pulse: firmware read the setup bytes from buffer memory.
    input wire logic [EP_COUNT-1:0] buf1_done, // Pulses: first buffer complete, per endpoint.
    input wire logic [EP_COUNT-1:0] buf2_done, // Pulses: second buffer complete, endpoint 0 unused.
    input wire logic [EP_COUNT-1:0] endpoint_direction, // Per endpoint, one for IN.
    input wire logic [EP_COUNT-1:0] token_valid, // Per endpoint: a host token targets it now.
    input wire logic [EP_COUNT-1:0] token_buf2, // Per endpoint: token aims at the second buffer.
    output logic [EP_COUNT-1:0] token_nak, // Per endpoint: answer the token with NAK.
    output logic [EP_COUNT-1:0] token_tx, // Per endpoint: ready buffer transmits.
    output logic [EP_COUNT-1:0] token_rx, // Per endpoint: ready buffer receives.
    output usb_regs_pkg::test_mode_e test_mode, // Selected test mode.
    output logic irq // Level interrupt request.
);
    logic [3:0] lines_sync;
    logic [31:0] interrupt_mask;
    logic [31:0] event_flags;
    logic [31:0] buffer_ready_flags;
    logic [31:0] next_interrupt_mask;
    logic [31:0] next_event_flags;
    logic [31:0] next_buffer_ready_flags;
    usb_regs_pkg::test_mode_e next_test_mode;
    usb_regs_pkg::bus_state_e bus_state;
    usb_regs_pkg::bus_state_e next_bus_state;
    logic [31:0] next_bus_rdata;
    logic next_irq;
    logic take;
    logic take_read;
    logic take_write;
    logic write_mask;
    logic write_ready;
    logic write_mode;
    logic read_flags;
    logic [2:0] mode_code;
    logic [31:0] pending;
    logic [31:0] ev_set;
    logic [31:0] ev_clr;
    logic [31:0] br_clr;
    logic [31:0] rd_word;

    // Synchronised bit order: 0 disconnect, 1 high speed, 2 bus reset, 3 suspend.
    sync_bits #(.WIDTH(4)) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .async_in({line_suspend, line_reset, line_high_speed, line_disconnect}),
        .sync_out(lines_sync)
    );

    // An access is taken only from idle, so a select still held in the ack cycle is not taken twice.
    assign take = bus_select && (bus_state == usb_regs_pkg::BUS_IDLE);
    assign take_read = take && bus_rnw;
    assign take_write = take && !bus_rnw;

    // Completion events mapped onto flag positions; endpoint n sits at high bit minus n.
    always_comb begin
        ev_set = '0;
        ev_set[`BIT_USB_RESET] = lines_sync[2];
        ev_set[`BIT_SUSPEND] = lines_sync[3];
        ev_set[`BIT_DISCONNECT] = lines_sync[0];
        ev_set[`BIT_EP0_RX] = ep0_rx_done;
        ev_set[`BIT_EP0_TX] = ep0_tx_done;
        ev_set[`BIT_SETUP] = setup_rx;
        ev_set[`BIT_SOF] = sof_rx;
        ev_set[`BIT_HIGH_SPEED] = lines_sync[1];
        ev_set[`BIT_EP0_BUF] = buf1_done[0];
        br_clr = '0;
        br_clr[`BIT_EP0_BUF] = buf1_done[0] && endpoint_direction[0];
    end

    // Flags of endpoints 1 and up built by one loop so the bit order cannot drift.
    logic [31:0] ep_set;
    logic [31:0] ep_clr;
    always_comb begin
        ep_set = ev_set;
        ep_clr = br_clr;
        for (int e = 1; e < EP_COUNT; e++) begin
            ep_set[`BIT_UNUSED - e] = buf2_done[e];
            ep_set[`BIT_EP0_BUF - e] = buf1_done[e];
            ep_clr[`BIT_UNUSED - e] = buf2_done[e] && endpoint_direction[e];
            ep_clr[`BIT_EP0_BUF - e] = buf1_done[e] && endpoint_direction[e];
        end
    end

    // Token answers per endpoint; endpoint zero has no second buffer, so its buffer select is ignored.
    for (genvar e = 0; e < EP_COUNT; e++) begin : g_ep
        logic rdy_first;
        logic rdy;
        assign rdy_first = buffer_ready_flags[`BIT_EP0_BUF - e];
        if (e == 0) begin : g_single
            assign rdy = rdy_first;
        end else begin : g_pair
            logic rdy_second;
            assign rdy_second = buffer_ready_flags[`BIT_UNUSED - e];
            assign rdy = token_buf2[e] ? rdy_second : rdy_first;
        end
        assign token_nak[e] = token_valid[e] && !rdy;
        assign token_tx[e] = token_valid[e] && rdy && endpoint_direction[e];
        assign token_rx[e] = token_valid[e] && rdy && !endpoint_direction[e];
    end

    // Unmapped offsets read zero, and reserved bits of mapped registers read zero as well.
    always_comb begin
        rd_word = '0;
        unique case (bus_addr)
            `OFS_EVENT_FLAGS: rd_word = event_flags;
            `OFS_INTERRUPT_MASK: rd_word = interrupt_mask;
            `OFS_BUFFER_READY: rd_word = buffer_ready_flags & `BUF_READY_WMASK;
            `OFS_TEST_MODE: rd_word = {test_mode, 29'h0};
            default: rd_word = '0;
        endcase
    end

    // Bus handshake: one answer cycle after every taken access, read data only inside it.
    always_comb begin
        next_bus_state = usb_regs_pkg::BUS_IDLE;
        next_bus_rdata = `RESET_WORD;
        if (take) begin
            next_bus_state = usb_regs_pkg::BUS_ACK;
        end
        if (take_read) begin
            next_bus_rdata = rd_word;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_state <= usb_regs_pkg::BUS_IDLE;
            bus_rdata <= `RESET_WORD;
        end else begin
            bus_state <= next_bus_state;
            bus_rdata <= next_bus_rdata;
        end
    end

    assign bus_ack = (bus_state == usb_regs_pkg::BUS_ACK);

    assign write_mask = take_write && (bus_addr == `OFS_INTERRUPT_MASK);
    assign write_ready = take_write && (bus_addr == `OFS_BUFFER_READY);
    assign write_mode = take_write && (bus_addr == `OFS_TEST_MODE);
    assign read_flags = take_read && (bus_addr == `OFS_EVENT_FLAGS);

    always_comb begin
        next_interrupt_mask = interrupt_mask;
        if (write_mask) begin
            next_interrupt_mask = bus_wdata & `INT_MASK_WMASK;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            interrupt_mask <= `RESET_WORD;
        end else begin
            interrupt_mask <= next_interrupt_mask;
        end
    end

    always_comb begin
        ev_clr = '0;
        if (read_flags) begin
            ev_clr = event_flags;
        end
        if (setup_read) begin
            ev_clr[`BIT_SETUP] = 1'b1;
        end
        // Set wins over clear so an event landing on the read is kept for the next read.
        next_event_flags = (event_flags & ~ev_clr) | ep_set;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            event_flags <= `RESET_WORD;
        end else begin
            event_flags <= next_event_flags;
        end
    end

    always_comb begin
        next_buffer_ready_flags = buffer_ready_flags & ~ep_clr;
        // A firmware write in the same cycle wins, so a buffer refilled at once is not lost.
        if (write_ready) begin
            next_buffer_ready_flags = bus_wdata & `BUF_READY_WMASK;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            buffer_ready_flags <= `RESET_WORD;
        end else begin
            buffer_ready_flags <= next_buffer_ready_flags;
        end
    end

    // Codes above the last defined mode are ignored, so the field never holds an illegal mode.
    assign mode_code = bus_wdata[31:`TEST_MODE_LSB];

    always_comb begin
        next_test_mode = test_mode;
        if (write_mode) begin
            unique case (mode_code)
                3'h0, 3'h1, 3'h2, 3'h3, 3'h4: begin
                    next_test_mode = usb_regs_pkg::test_mode_e'(mode_code);
                end
                default: begin
                    next_test_mode = test_mode;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            test_mode <= usb_regs_pkg::TM_NORMAL;
        end else begin
            test_mode <= next_test_mode;
        end
    end

    // The request is registered, so it follows the flags by one cycle and never glitches.
    always_comb begin
        pending = event_flags & interrupt_mask & `IRQ_SOURCE_MASK;
        next_irq = interrupt_mask[`BIT_MASTER_EN] && (|pending);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end
endmodule

// ---- testbench/usb_regs_asserts.sv ----
// Concurrent checks on the bus and token ports of the register bank.
`timescale 1ns/1ps
module usb_regs_asserts #(
    parameter int EP_COUNT = 8
) (
    input wire logic clk, // Clock.
    input wire logic arst_n, // Reset, active low.
    input wire logic bus_select, // Select.
    input wire logic bus_rnw, // Read not write.
    input wire logic [7:0] bus_addr, // Address.
    input wire logic [31:0] bus_wdata, // Write data.
    input wire logic [31:0] bus_rdata, // Read data.
    input wire logic bus_ack, // Acknowledge.
    input wire logic [EP_COUNT-1:0] endpoint_direction, // One for IN.
    input wire logic [EP_COUNT-1:0] token_nak, // NAK answer.
    input wire logic [EP_COUNT-1:0] token_tx, // Transmit.
    input wire logic [EP_COUNT-1:0] token_rx, // Receive.
    input wire usb_regs_pkg::test_mode_e test_mode // Mode.
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_ack_single: assert property (bus_ack |=> !bus_ack) else $error("ack too long");
    chk_ack_taken: assert property (bus_select && !bus_ack |=> bus_ack) else $error("access not answered");
    chk_ack_cause: assert property (bus_ack |-> $past(bus_select)) else $error("ack without select");
    chk_rdata_idle: assert property (!bus_ack |-> bus_rdata == 32'h0) else $error("read data outside ack");
    chk_mode_legal: assert property (test_mode <= 3'h4) else $error("illegal test mode");
    chk_mode_write: assert property (bus_select && !bus_ack && !bus_rnw && bus_addr == 8'h0c &&
        bus_wdata[31:29] <= 3'h4 |=> test_mode == $past(bus_wdata[31:29])) else $error("mode not taken");
    chk_nak_excl: assert property ((token_nak & (token_tx | token_rx)) == '0) else $error("nak with data");
    chk_dir_in: assert property ((token_tx & ~endpoint_direction) == '0) else $error("tx on OUT");
    chk_dir_out: assert property ((token_rx & endpoint_direction) == '0) else $error("rx on IN");
endmodule
bind usb_device_irq_bufready_testmode_regs usb_regs_asserts #(.EP_COUNT(EP_COUNT)) u_chk (.clk, .arst_n,
    .bus_select, .bus_rnw, .bus_addr, .bus_wdata, .bus_rdata, .bus_ack, .endpoint_direction, .token_nak,
    .token_tx, .token_rx, .test_mode);

// ---- testbench/fw_bus_master.sv ----
// Firmware-side master that makes single register accesses.
`timescale 1ns/1ps
module fw_bus_master (
    input wire logic clk, // Clock.
    input wire logic bus_ack, // Acknowledge.
    input wire logic [31:0] bus_rdata, // Read data.
    output logic bus_select = 1'b0, // Select.
    output logic bus_rnw = 1'b1, // Read not write.
    output logic [7:0] bus_addr = 8'h00, // Address.
    output logic [31:0] bus_wdata = 32'h0 // Write data.
);
    // Select drops at the ack edge so one access is never taken twice; address and write data then show the inverse.
    task automatic access(input logic rnw, input logic [7:0] addr, input logic [31:0] wdata,
        output logic [31:0] rdata);
        int n;
        n = 0;
        @(posedge clk);
        bus_select <= 1'b1;
        bus_rnw <= rnw;
        bus_addr <= addr;
        bus_wdata <= wdata;
        do @(posedge clk); while (bus_ack !== 1'b1 && ++n < 20);
        rdata = bus_rdata;
        if (bus_ack !== 1'b1) begin
            rdata = 'x;
        end
        bus_select <= 1'b0;
        bus_addr <= ~addr;
        bus_wdata <= ~wdata;
    endtask
endmodule

// ---- testbench/test_usb_device_irq_bufready_testmode_regs.sv ----
// Self-checking bench for the USB device register bank.
`timescale 1ns/1ps
`include "usb_regs_map.svh"
module test_usb_device_irq_bufready_testmode_regs;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic sr = 1'b0;
    logic [7:0] src = 8'h00, b1 = 8'h00, b2 = 8'h00, dir = 8'h00, tv = 8'h00, tb2 = 8'h00;
    logic bus_select, bus_rnw, bus_ack, irq;
    logic [7:0] bus_addr, tnak, ttx, trx;
    logic [31:0] bus_wdata, bus_rdata, rd, lf;
    usb_regs_pkg::test_mode_e tm;
    int n_mismatch = 0, comparisons = 0;
    int bits[8] = '{11, 12, 13, 14, 10, 15, 8, 9};
    always #5 clk = ~clk;
    usb_device_irq_bufready_testmode_regs #(.EP_COUNT(8)) dut (.clk, .arst_n, .bus_select, .bus_rnw, .bus_addr,
        .bus_wdata, .bus_rdata, .bus_ack, .line_disconnect(src[4]), .line_high_speed(src[5]), .line_reset(src[6]),
        .line_suspend(src[7]), .ep0_rx_done(src[0]), .ep0_tx_done(src[1]), .setup_rx(src[2]), .sof_rx(src[3]),
        .setup_read(sr), .buf1_done(b1), .buf2_done(b2), .endpoint_direction(dir), .token_valid(tv),
        .token_buf2(tb2), .token_nak(tnak), .token_tx(ttx), .token_rx(trx), .test_mode(tm), .irq);
    fw_bus_master fw (.clk, .bus_ack, .bus_rdata, .bus_select, .bus_rnw, .bus_addr, .bus_wdata);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [31:0] bufbit(input int e, input int s);
        return 32'h1 << ((s != 0 ? 23 : 31) - e);
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        fw.access(1'b0, a, d, rd);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        fw.access(1'b1, a, 32'h0, rd);
        chk(rd, exp);
    endtask
    // Level sources pass a two-flop synchroniser, so five idle cycles cover the longest path to irq.
    task automatic pulse(input int k);
        @(posedge clk);
        src[k] <= 1'b1;
        @(posedge clk);
        src <= 8'h00;
        repeat (5) @(posedge clk);
    endtask
    initial begin
        int e;
        int s;
        lf = 32'd93;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        rdc(`OFS_INTERRUPT_MASK, `RESET_WORD);
        rdc(`OFS_BUFFER_READY, `RESET_WORD);
        rdc(`OFS_TEST_MODE, `RESET_WORD);
        rdc(8'h10, 32'h0);
        wr(`OFS_INTERRUPT_MASK, 32'hffff_ffff);
        rdc(`OFS_INTERRUPT_MASK, `INT_MASK_WMASK);
        lf = nxt(lf);
        wr(`OFS_BUFFER_READY, lf);
        rdc(`OFS_BUFFER_READY, lf & `BUF_READY_WMASK);
        for (int v = 0; v < 8; v++) begin
            lf = nxt(lf);
            wr(`OFS_TEST_MODE, {v[2:0], lf[28:0]});
            chk({29'h0, tm}, v < 5 ? v : 4);
            rdc(`OFS_TEST_MODE, {(v < 5 ? v[2:0] : 3'h4), 29'h0});
        end
        for (int i = 0; i < 8; i++) begin
            wr(`OFS_INTERRUPT_MASK, (32'h1 << bits[i]) | 32'h1);
            pulse(i);
            chk({31'h0, irq}, 32'h1);
            rdc(`OFS_EVENT_FLAGS, 32'h1 << bits[i]);
            rdc(`OFS_EVENT_FLAGS, 32'h0);
            chk({31'h0, irq}, 32'h0);
            wr(`OFS_INTERRUPT_MASK, 32'h1 << bits[i]);
            pulse(i);
            chk({31'h0, irq}, 32'h0);
            rdc(`OFS_EVENT_FLAGS, 32'h1 << bits[i]);
        end
        // Endpoint setup, the run bit and the device address live outside this bank; the bench plays
        // that firmware by driving the endpoint direction levels directly.
        pulse(2);
        sr <= 1'b1;
        @(posedge clk);
        sr <= 1'b0;
        rdc(`OFS_EVENT_FLAGS, 32'h0);
        for (int k = 0; k < 8; k++) begin
            lf = nxt(lf);
            e = (k == 0) ? 0 : 1 + lf % 7;
            s = (e != 0 && lf[8]) ? 1 : 0;
            wr(`OFS_BUFFER_READY, 32'h0);
            tv <= 8'h1 << e;
            tb2 <= 8'(s) << e;
            dir <= 8'hff;
            @(posedge clk);
            chk({31'h0, tnak[e]}, 32'h1);
            wr(`OFS_BUFFER_READY, bufbit(e, s));
            chk({30'h0, ttx[e], tnak[e]}, 32'h2);
            dir <= 8'h00;
            @(posedge clk);
            chk({30'h0, trx[e], ttx[e]}, 32'h2);
            dir <= 8'hff;
            if (s != 0) b2 <= 8'h1 << e;
            else b1 <= 8'h1 << e;
            @(posedge clk);
            b1 <= 8'h00;
            b2 <= 8'h00;
            tv <= 8'h00;
            rdc(`OFS_BUFFER_READY, 32'h0);
            rdc(`OFS_EVENT_FLAGS, bufbit(e, s));
        end
        end_sim();
    end
    initial begin
        #500us;
        n_mismatch++;
        end_sim();
    end
endmodule
